// ---- pkg/light_sensor_pkg.sv ----
// light sensor control package: register map, field layout, timing, carriers
// assumes a 40 MHz system clock and a byte-wide register pointer

package light_sensor_pkg;

    // ------------------------------------------------------------
    // register map
    // ------------------------------------------------------------
    localparam logic [7:0]  RESULT_ADDR   = 8'h00;
    localparam logic [7:0]  CONTROL_ADDR  = 8'h01;
    localparam logic [15:0] CONTROL_RESET = 16'hC810;

    // ------------------------------------------------------------
    // field positions of measurement_control
    // ------------------------------------------------------------
    localparam int RANGE_MSB = 15;
    localparam int RANGE_LSB = 12;
    localparam int INTEG_BIT = 11;
    localparam int MODE_MSB  = 10;
    localparam int MODE_LSB  = 9;
    localparam int OVF_BIT   = 8;
    localparam int DONE_BIT  = 7;
    localparam int LOW_MSB   = 4;

    // ------------------------------------------------------------
    // range codes and operating modes
    // ------------------------------------------------------------
    localparam logic [3:0] RANGE_AUTO = 4'hC;
    localparam logic [3:0] RANGE_MAX  = 4'hB;
    localparam logic [3:0] RANGE_MIN  = 4'h0;

    typedef enum logic [1:0] {
        MODE_SHUTDOWN = 2'b00,
        MODE_SINGLE   = 2'b01,
        MODE_CONT     = 2'b10,
        MODE_CONT_ALT = 2'b11
    } op_mode_t;

    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam int CLK_HZ        = 40_000_000;
    localparam int SHORT_TIME_MS = 100;
    localparam int LONG_TIME_MS  = 800;
    localparam int SHORT_CYCLES  = SHORT_TIME_MS * (CLK_HZ / 1000);
    localparam int LONG_CYCLES   = LONG_TIME_MS * (CLK_HZ / 1000);

    // ------------------------------------------------------------
    // carriers
    // ------------------------------------------------------------
    typedef struct packed {
        logic        wrEn;
        logic        rdEn;
        logic [7:0]  addr;
        logic [15:0] wrData;
    } reg_req_t;

    typedef struct packed {
        logic        overflow;
        logic [11:0] count;
    } afe_in_t;

    typedef struct packed {
        logic       integrating;
        logic [3:0] range;
    } afe_out_t;

endpackage

// ---- design/light_conv_timer.sv ----
// integration timer: counts one conversion of short or long length
// assumes start and abort are single-cycle pulses from the control block

`timescale 1ns/1ps

module light_conv_timer #(
    parameter int SHORT_CYCLES = light_sensor_pkg::SHORT_CYCLES,
    parameter int LONG_CYCLES  = light_sensor_pkg::LONG_CYCLES
) (
    input  wire logic clk_sys,   // system clock
    input  wire logic reset_n,   // async reset, active low
    input  wire logic start,     // begin a fresh conversion
    input  wire logic abort,     // stop the running conversion
    input  wire logic useLong,   // long integration selected
    output logic      busy,      // conversion running
    output logic      done       // last cycle of a conversion
);
    import light_sensor_pkg::*;

    localparam int CW = $clog2(LONG_CYCLES + 1);

    typedef enum logic {
        T_IDLE = 1'b0,
        T_RUN  = 1'b1
    } timer_state_t;

    timer_state_t   state;
    logic [CW-1:0]  count;
    logic           longSel;
    logic [CW-1:0]  limit;

    if (SHORT_CYCLES < 2 || LONG_CYCLES < SHORT_CYCLES) begin : g_bad
        $error("conversion lengths out of range");
    end

    // ------------------------------------------------------------
    // sequencing
    // ------------------------------------------------------------
    // length is latched at start so a conversion keeps its own setting
    assign limit = longSel ? CW'(LONG_CYCLES - 1) : CW'(SHORT_CYCLES - 1);
    assign busy  = (state == T_RUN);
    // start is left out on purpose: restarts are formed from done, so a
    // term on start here would close a combinational loop; a start from a
    // write while busy always comes with abort, which already blocks done
    assign done  = busy && (count == limit) && !abort;

    // state and cycle count; start restarts even a running conversion
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            state   <= T_IDLE;
            count   <= '0;
            longSel <= 1'b0;
        end else if (start) begin
            state   <= T_RUN;
            count   <= '0;
            longSel <= useLong;
        end else if (abort || done) begin
            state <= T_IDLE;
            count <= '0;
        end else if (busy) begin
            count <= count + CW'(1);
        end
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    logic [CW-1:0] elapsed;

    // independent cycle count since the last start
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            elapsed <= '0;
        end else if (start) begin
            elapsed <= '0;
        end else if (busy) begin
            elapsed <= elapsed + CW'(1);
        end
    end

    chk_conv_length: assert property (
        @(posedge clk_sys) disable iff (!reset_n)
        done |-> elapsed == (longSel ? CW'(LONG_CYCLES - 1) : CW'(SHORT_CYCLES - 1)))
        else $error("conversion length wrong");

endmodule

// ---- design/light_sensor_config_control.sv ----
// measurement control register and conversion sequencing of a light sensor
// assumes a serial bus front end that presents one register access per cycle
// and an integrating converter that reports count and overflow at the end
//
// How it works
// - control write aborts a running conversion immediately
// - write selecting conversion starts fresh with new settings
// - control register at 01h, resets to C810h
// - bits 15:12 select range like result exponent
// - code 1100b ranges automatically, exponent reports choice
// - bit 11: 0 gives 100 ms, 1 800 ms
// - short integration drops low bits on low ranges
// - result layout and weight independent of integration
// - bits 10:9: shutdown, single, continuous twice
// - single-shot code reads back while converting
// - single-shot end clears mode to shutdown
// - bits 8:5 read-only, others writable
// - done flag set at end, cleared by control read or converting write
// - auto overflow below range 1011b raises range and restarts conversion
// - result holds 4-bit exponent, 12-bit count

`timescale 1ns/1ps

module light_sensor_config_control #(
    parameter int SHORT_CYCLES = light_sensor_pkg::SHORT_CYCLES,
    parameter int LONG_CYCLES  = light_sensor_pkg::LONG_CYCLES
) (
    input  wire logic                       clk_sys,  // system clock, 40 MHz
    input  wire logic                       reset_n,  // async reset, active low
    input  wire light_sensor_pkg::reg_req_t regReq,   // register access request
    output logic [15:0]                     rdData,   // read data, registered
    input  wire light_sensor_pkg::afe_in_t  afeIn,    // converter count and overflow
    output light_sensor_pkg::afe_out_t      afeOut    // converter control
);
    import light_sensor_pkg::*;

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    logic [3:0]  rangeSel;
    logic        integLong;
    op_mode_t    opMode;
    logic [4:0]  lowCfg;
    logic        ovfFlag;
    logic        doneFlag;
    logic        raised;
    logic [3:0]  curRange;
    logic [3:0]  resultExp;
    logic [11:0] resultCount;

    logic        cfgWrite;
    logic        cfgRead;
    op_mode_t    newMode;
    logic [3:0]  newRange;
    logic        autoMode;
    logic        busy;
    logic        convDone;
    logic        rangeUp;
    logic        finalDone;
    logic        startConv;
    logic        abortConv;
    logic [15:0] controlView;

    // drop low bits that a short integration cannot resolve
    function automatic logic [11:0] trimCount(input logic [11:0] raw,
                                              input logic [3:0]  rng,
                                              input logic        longInt);
        logic [11:0] res;
        res = raw;
        if (!longInt) begin
            if (rng == 4'h5) begin
                res = {raw[11:1], 1'h0};
            end else if (rng >= 4'h1 && rng <= 4'h4) begin
                res = {raw[11:2], 2'h0};
            end else if (rng == 4'h0) begin
                res = {raw[11:3], 3'h0};
            end
        end
        return res;
    endfunction

    // ------------------------------------------------------------
    // decode
    // ------------------------------------------------------------
    assign cfgWrite = regReq.wrEn && (regReq.addr == CONTROL_ADDR);
    assign cfgRead  = regReq.rdEn && (regReq.addr == CONTROL_ADDR);
    assign newMode  = op_mode_t'(regReq.wrData[MODE_MSB:MODE_LSB]);
    assign newRange = regReq.wrData[RANGE_MSB:RANGE_LSB];
    assign autoMode = (rangeSel == RANGE_AUTO);

    // auto overflow below top range restarts one range higher
    assign rangeUp   = convDone && !cfgWrite && autoMode && afeIn.overflow
                       && (curRange < RANGE_MAX);
    assign finalDone = convDone && !cfgWrite && !rangeUp;
    // a write kills the conversion; a converting mode restarts it
    assign abortConv = cfgWrite && busy;
    assign startConv = (cfgWrite && newMode != MODE_SHUTDOWN)
                       || rangeUp
                       || (finalDone && opMode[1]);

    light_conv_timer #(
        .SHORT_CYCLES (SHORT_CYCLES),
        .LONG_CYCLES  (LONG_CYCLES)
    ) u_timer (
        .clk_sys (clk_sys),
        .reset_n (reset_n),
        .start   (startConv),
        .abort   (abortConv),
        .useLong (cfgWrite ? regReq.wrData[INTEG_BIT] : integLong),
        .busy    (busy),
        .done    (convDone)
    );

    assign afeOut.integrating = busy;
    assign afeOut.range       = curRange;

    // ------------------------------------------------------------
    // writable settings
    // ------------------------------------------------------------
    // only bits 15:9 and 4:0 are stored from a write
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            rangeSel  <= CONTROL_RESET[RANGE_MSB:RANGE_LSB];
            integLong <= CONTROL_RESET[INTEG_BIT];
            lowCfg    <= CONTROL_RESET[LOW_MSB:0];
        end else if (cfgWrite) begin
            rangeSel  <= newRange;
            integLong <= regReq.wrData[INTEG_BIT];
            lowCfg    <= regReq.wrData[LOW_MSB:0];
        end
    end

    // operating mode; single shot falls back to shutdown when it ends
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            opMode <= op_mode_t'(CONTROL_RESET[MODE_MSB:MODE_LSB]);
        end else if (cfgWrite) begin
            opMode <= newMode;
        end else if (finalDone && opMode == MODE_SINGLE) begin
            opMode <= MODE_SHUTDOWN;
        end
    end

    // working range: manual code, or auto search from the lowest range
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            curRange <= RANGE_MIN;
        end else if (cfgWrite) begin
            curRange <= (newRange == RANGE_AUTO) ? RANGE_MIN : newRange;
        end else if (rangeUp) begin
            curRange <= curRange + 4'h1;
        end
    end

    // ------------------------------------------------------------
    // status flags
    // ------------------------------------------------------------
    // remembers that the current measurement climbed at least one range
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            raised <= 1'b0;
        end else if (cfgWrite) begin
            raised <= 1'b0;
        end else if (rangeUp) begin
            raised <= 1'b1;
        end else if (finalDone) begin
            raised <= 1'b0;
        end
    end

    // overflow re-evaluated at the end of every measurement
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            ovfFlag <= CONTROL_RESET[OVF_BIT];
        end else if (finalDone) begin
            ovfFlag <= afeIn.overflow || raised;
        end
    end

    // done flag: completion wins over a clear in the same cycle
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            doneFlag <= CONTROL_RESET[DONE_BIT];
        end else if (finalDone) begin
            doneFlag <= 1'b1;
        end else if (cfgRead || (cfgWrite && newMode != MODE_SHUTDOWN)) begin
            doneFlag <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // result word
    // ------------------------------------------------------------
    // exponent is the range used; count weight never depends on integration
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            resultExp   <= 4'h0;
            resultCount <= 12'h000;
        end else if (finalDone) begin
            resultExp   <= curRange;
            resultCount <= trimCount(afeIn.count, curRange, integLong);
        end
    end

    // ------------------------------------------------------------
    // read port
    // ------------------------------------------------------------
    assign controlView = {rangeSel, integLong, opMode, ovfFlag, doneFlag,
                          2'h0, lowCfg};

    // read data sampled at the access; unmapped addresses read zero
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            rdData <= 16'h0000;
        end else if (regReq.rdEn) begin
            unique case (regReq.addr)
                RESULT_ADDR:  rdData <= {resultExp, resultCount};
                CONTROL_ADDR: rdData <= controlView;
                default:      rdData <= 16'h0000;
            endcase
        end
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    logic anyWrite;

    // notes whether the control register was ever written since reset
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            anyWrite <= 1'b0;
        end else if (cfgWrite) begin
            anyWrite <= 1'b1;
        end
    end

    chk_reset_settings: assert property (
        @(posedge clk_sys) disable iff (!reset_n)
        !anyWrite |-> (controlView[15:9] == CONTROL_RESET[15:9]
                       && controlView[4:0] == CONTROL_RESET[4:0]))
        else $error("control settings left reset value without a write");

    chk_write_abort: assert property (
        @(posedge clk_sys) disable iff (!reset_n)
        (cfgWrite && busy && newMode == MODE_SHUTDOWN) |=> !busy && !convDone)
        else $error("conversion survived a shutdown write");

    chk_write_restart: assert property (
        @(posedge clk_sys) disable iff (!reset_n)
        (cfgWrite && newMode != MODE_SHUTDOWN) |=> busy && !convDone
            && opMode == $past(newMode))
        else $error("no fresh conversion after a converting write");

    chk_manual_range: assert property (
        @(posedge clk_sys) disable iff (!reset_n)
        (cfgWrite && newRange < RANGE_AUTO) |=> afeOut.range == $past(newRange))
        else $error("manual range not driven");

    chk_auto_raise: assert property (
        @(posedge clk_sys) disable iff (!reset_n)
        rangeUp |=> busy && afeOut.range == $past(curRange) + 4'h1
            && resultCount == $past(resultCount))
        else $error("auto range did not step up");

    chk_single_hold: assert property (
        @(posedge clk_sys) disable iff (!reset_n)
        (opMode == MODE_SINGLE && busy && !convDone && !cfgWrite)
            |=> opMode == MODE_SINGLE)
        else $error("single-shot mode dropped while converting");

    chk_single_clear: assert property (
        @(posedge clk_sys) disable iff (!reset_n)
        (finalDone && opMode == MODE_SINGLE) |=> opMode == MODE_SHUTDOWN && !busy)
        else $error("single-shot did not return to shutdown");

    chk_done_flag: assert property (
        @(posedge clk_sys) disable iff (!reset_n)
        finalDone |=> doneFlag ##1 (doneFlag || $past(cfgRead || cfgWrite)))
        else $error("done flag not set or lost");

    chk_status_ro: assert property (
        @(posedge clk_sys) disable iff (!reset_n)
        (cfgWrite && !finalDone) |=> ovfFlag == $past(ovfFlag))
        else $error("write changed the overflow flag");

endmodule

// ---- test/light_afe_model.sv ----
// converter stand-in: returns a count and overflows below a chosen range
// assumes afeOut from the control block and levels set by the bench at clock edges

`timescale 1ns/1ps

module light_afe_model (
    input  wire logic                       clk_sys,    // system clock
    input  wire logic                       reset_n,    // async reset, active low
    input  wire light_sensor_pkg::afe_out_t afeOut,     // converter control
    input  wire logic [3:0]                 lightLevel, // lowest range without overflow
    input  wire logic [11:0]                countVal,   // count at conversion end
    output light_sensor_pkg::afe_in_t       afeIn       // count and overflow
);
    logic toggle;

    // ------------------------------------------------------------
    // idle pattern
    // ------------------------------------------------------------
    // changes every cycle so a sample taken outside a conversion never looks valid
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            toggle <= 1'b0;
        end else begin
            toggle <= ~toggle;
        end
    end

    // ------------------------------------------------------------
    // converter outputs
    // ------------------------------------------------------------
    // overflow while the range in use is below the light level
    assign afeIn.overflow = afeOut.integrating ? (afeOut.range < lightLevel) : toggle;
    assign afeIn.count    = afeOut.integrating ? countVal : (toggle ? ~countVal : 12'hA5A);
endmodule

// ---- test/light_sensor_config_control_test.sv ----
// self-checking bench for the measurement control block
// assumes the converter model beside it and shortened conversion lengths

`timescale 1ns/1ps

module light_sensor_config_control_test;
    import light_sensor_pkg::*;
    localparam int SHORT_T    = 20;
    localparam int LONG_T     = 80;
    localparam int MAX_CYCLES = 20000;

    logic        clk_sys;
    logic        reset_n;
    reg_req_t    regReq;
    logic [15:0] rdData;
    afe_in_t     afeIn;
    afe_out_t    afeOut;
    logic [3:0]  lightLevel;
    logic [11:0] countVal;
    int          miscompares;
    int          tests_run;
    int          cycles;
    int          n;
    logic [15:0] rv;
    logic [15:0] lastRes;
    logic [3:0]  r;
    logic        lg;
    logic [4:0]  lo;
    logic [3:0]  lvl [3] = '{4'h3, 4'hF, 4'h0};
    logic [3:0]  expR [3] = '{4'h3, 4'hB, 4'h0};

    light_sensor_config_control #(.SHORT_CYCLES(SHORT_T), .LONG_CYCLES(LONG_T))
    light_sensor_config_control_i (.clk_sys(clk_sys), .reset_n(reset_n), .regReq(regReq),
        .rdData(rdData), .afeIn(afeIn), .afeOut(afeOut));

    light_afe_model light_afe_model_i (.clk_sys(clk_sys), .reset_n(reset_n), .afeOut(afeOut),
        .lightLevel(lightLevel), .countVal(countVal), .afeIn(afeIn));

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    task automatic give_verdict();
        $display("comparisons %0d mismatches %0d", tests_run, miscompares);
        if (miscompares == 0 && tests_run > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        tests_run++;
        if (got !== exp) begin
            miscompares++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // one write: strobe for a single edge
    task automatic wr(input logic [15:0] d);
        @(posedge clk_sys);
        regReq <= '{1'b1, 1'b0, CONTROL_ADDR, d};
        @(posedge clk_sys);
        regReq <= '0;
        #1;
    endtask

    // one read: data is registered at the taking edge
    task automatic rd(input logic [7:0] a, output logic [15:0] d);
        @(posedge clk_sys);
        regReq <= '{1'b0, 1'b1, a, 16'h0000};
        @(posedge clk_sys);
        regReq <= '0;
        #1;
        d = rdData;
    endtask

    // counts the cycles a conversion stays active
    task automatic wait_idle(output int cnt);
        cnt = 0;
        while (afeOut.integrating === 1'b1 && cnt < 3000) begin
            @(posedge clk_sys);
            #1;
            cnt++;
        end
    endtask

    // expected result word, low bits dropped for short integration
    function automatic logic [15:0] exp_res(input logic [3:0] rg, input logic li,
                                            input logic [11:0] c);
        logic [11:0] m;
        m = c;
        if (!li && rg == 4'h5) m[0] = 1'b0;
        else if (!li && rg >= 4'h1 && rg <= 4'h4) m[1:0] = 2'b00;
        else if (!li && rg == 4'h0) m[2:0] = 3'b000;
        return {rg, m};
    endfunction

    function automatic logic [15:0] ctl(input logic [3:0] rg, input logic li,
        input logic [1:0] md, input logic ov, input logic dn, input logic [4:0] lw);
        return {rg, li, md, ov, dn, 2'b00, lw};
    endfunction

    // ------------------------------------------------------------
    // clock and watchdog
    // ------------------------------------------------------------
    initial begin
        clk_sys = 1'b0;
        forever #12.5 clk_sys = ~clk_sys;
    end

    // a hang counts as a mismatch
    always @(posedge clk_sys) begin
        cycles++;
        if (cycles >= MAX_CYCLES) begin
            miscompares++;
            give_verdict();
        end
    end

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        reset_n = 1'b0;
        regReq = '0;
        lightLevel = 4'h0;
        countVal = 12'h000;
        miscompares = 0;
        tests_run = 0;
        cycles = 0;
        void'($urandom(32'h7fdb));
        repeat (2) @(posedge clk_sys);
        reset_n <= 1'b1;
        rd(CONTROL_ADDR, rv);
        check(rv, CONTROL_RESET);
        check({11'h000, afeOut}, 16'h0000);
        rd(RESULT_ADDR, rv);
        check(rv, 16'h0000);
        rd(8'h05, rv);
        check(rv, 16'h0000);
        wr(16'h01FF);
        rd(CONTROL_ADDR, rv);
        check(rv, 16'h001F);
        // manual single shots over every range and both lengths
        for (int i = 0; i < 24; i++) begin
            r = 4'(i % 12); // reserved range codes never written
            lg = (i >= 12);
            lo = 5'($urandom);
            @(posedge clk_sys);
            countVal <= 12'($urandom);
            wr(ctl(r, lg, 2'b01, 1'b0, 1'b0, lo));
            check({12'h000, afeOut.range}, {12'h000, r});
            wait_idle(n);
            check(n[15:0], lg ? 16'(LONG_T) : 16'(SHORT_T));
            rd(CONTROL_ADDR, rv);
            check(rv, ctl(r, lg, 2'b00, 1'b0, 1'b1, lo));
            rd(CONTROL_ADDR, rv);
            check(rv, ctl(r, lg, 2'b00, 1'b0, 1'b0, lo));
            rd(RESULT_ADDR, lastRes);
            check(lastRes, exp_res(r, lg, countVal));
        end
        // abort by a shutdown write keeps the old result
        wr(ctl(4'h3, 1'b1, 2'b01, 1'b0, 1'b0, 5'h00));
        repeat (5) @(posedge clk_sys);
        rd(CONTROL_ADDR, rv);
        check(rv, ctl(4'h3, 1'b1, 2'b01, 1'b0, 1'b0, 5'h00));
        wr(ctl(4'h3, 1'b1, 2'b00, 1'b0, 1'b0, 5'h00));
        check({15'h0000, afeOut.integrating}, 16'h0000);
        repeat (LONG_T) @(posedge clk_sys);
        rd(RESULT_ADDR, rv);
        check(rv, lastRes);
        rd(CONTROL_ADDR, rv);
        check(rv, ctl(4'h3, 1'b1, 2'b00, 1'b0, 1'b0, 5'h00));
        // a write in mid-run restarts with the new length
        wr(ctl(4'h2, 1'b1, 2'b01, 1'b0, 1'b0, 5'h00));
        repeat (10) @(posedge clk_sys);
        wr(ctl(4'h2, 1'b0, 2'b01, 1'b0, 1'b0, 5'h00));
        wait_idle(n);
        check(n[15:0], 16'(SHORT_T));
        rd(RESULT_ADDR, rv);
        check(rv, exp_res(4'h2, 1'b0, countVal));
        wr(ctl(4'h2, 1'b0, 2'b00, 1'b0, 1'b0, 5'h00));
        rd(CONTROL_ADDR, rv);
        check(rv, ctl(4'h2, 1'b0, 2'b00, 1'b0, 1'b1, 5'h00));
        // both continuous codes keep converting
        for (int md = 2; md < 4; md++) begin
            @(posedge clk_sys);
            countVal <= 12'($urandom);
            wr(ctl(4'h6, 1'b0, 2'(md), 1'b0, 1'b0, 5'h00));
            repeat (2 * SHORT_T + 3) @(posedge clk_sys);
            #1;
            check({15'h0000, afeOut.integrating}, 16'h0001);
            rd(CONTROL_ADDR, rv);
            check(rv, ctl(4'h6, 1'b0, 2'(md), 1'b0, 1'b1, 5'h00));
            rd(RESULT_ADDR, rv);
            check(rv, exp_res(4'h6, 1'b0, countVal));
            wr(ctl(4'h6, 1'b0, 2'b00, 1'b0, 1'b0, 5'h00));
        end
        // automatic ranging: raise on overflow up to the top range
        for (int k = 0; k < 3; k++) begin
            @(posedge clk_sys);
            lightLevel <= lvl[k];
            countVal <= 12'($urandom);
            wr(ctl(RANGE_AUTO, 1'b1, 2'b01, 1'b0, 1'b0, 5'h00));
            wait_idle(n);
            rd(RESULT_ADDR, rv);
            check(rv, exp_res(expR[k], 1'b1, countVal));
            rd(CONTROL_ADDR, rv);
            check(rv, ctl(RANGE_AUTO, 1'b1, 2'b00, (k < 2), 1'b1, 5'h00));
        end
        give_verdict();
    end
endmodule
